// ### include/fspi_consts.svh
/*
 * Constants for the sensor serial slave port: timing figures and counts.
 * Assumes the core clock runs at 125 MHz; the counts derive from it.
 */
`ifndef FSPI_CONSTS_SVH
`define FSPI_CONSTS_SVH

// Core clock period in nanoseconds.
`define FSPI_CLK_PERIOD_NS 8
// Least time the standby input must be low to take effect, in ns.
`define FSPI_STANDBY_MIN_NS 100
// Least standby low time in cycles, rounded up.
`define FSPI_STANDBY_CYCLES ((`FSPI_STANDBY_MIN_NS + `FSPI_CLK_PERIOD_NS - 1) / `FSPI_CLK_PERIOD_NS)
// Longest time from power-on or standby release to normal mode, in ms.
`define FSPI_WAKE_MS 5
// Wake time in cycles, rounded down.
`define FSPI_WAKE_CYCLES ((`FSPI_WAKE_MS * 1000000) / `FSPI_CLK_PERIOD_NS)
// Reset value of the clock mode and of the first bit select.
`define FSPI_MODE_RESET 2'h0
`define FSPI_ORDER_RESET 1'h0
// Default position and read level of the read/write flag in the instruction.
`define FSPI_RW_BIT_DEFAULT 7
`define FSPI_RW_READ_DEFAULT 1

`endif

// ### include/fspi_pkg.sv
/*
 * Types for the sensor serial slave port.
 * Assumes fspi_consts.svh is included by the modules that need numbers.
 */
package fspi_pkg;

    // Which part of an operation a received byte belongs to.
    typedef enum logic [1:0] {
        FSPI_KIND_ADDR  = 2'h0,
        FSPI_KIND_INSTR = 2'h1,
        FSPI_KIND_DATA  = 2'h2
    } fspi_kind_t;

    // One received byte with its place in the operation.
    typedef struct packed {
        fspi_kind_t kind;
        logic [7:0] data;
    } fspi_rx_t;

    // Receive phase of an operation.
    typedef enum logic [3:0] {
        FSPI_ST_IDLE  = 4'h1,
        FSPI_ST_ADDR  = 4'h2,
        FSPI_ST_INSTR = 4'h4,
        FSPI_ST_DATA  = 4'h8
    } fspi_state_t;

    // Power state of the device.
    typedef enum logic [2:0] {
        FSPI_PW_WAKE  = 3'h1,
        FSPI_PW_RUN   = 3'h2,
        FSPI_PW_SLEEP = 3'h4
    } fspi_power_t;

endpackage

// ### core/fspi_buf.sv
/*
 * Small first-in first-out buffer with valid and ready on both sides.
 * Assumes both sides run on core_clk; read data come out of a register.
 */
`timescale 1ns/1ps
module fspi_buf #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refuse depths the pointer arithmetic cannot serve.
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("fspi_buf: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // Full and empty come from the pointer difference, never guessed.
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign push = in_valid && !full;
    assign pop = (!out_valid || out_ready) && !empty;
    assign in_ready = !full;

    // Storage write.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Output register, refilled when drained or empty.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem_reg[rd_ptr_reg[AW-1:0]];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule

// ### core/fspi_port.sv
/*
 * Serial slave port of a capacitive fingerprint sensor, with power-on and
 * standby control and the new-frame interrupt output.
 * Assumes all pins are asynchronous to core_clk and the serial clock is much
 * slower than core_clk; configuration comes in as plain ports.
 */
// Summary of operation
// [RQ1] Power-on reset reaches normal mode within 5 ms.
// [RQ2] Standby input low for 100 ns or more returns device to reset.
// [RQ3] After standby release, normal mode is reached within 5 ms.
// [RQ4] Host always drives standby; low then high is a completed reset.
// [RQ5] Whole chip sleeps in low power while standby is low.
// [RQ6] Host must reconfigure after standby, configuration is lost.
// [RQ7] Select high deselects the device; serial input is ignored.
// [RQ8] Operation starts at select falling and ends at select rising.
// [RQ9] Master first shifts in one 8-bit address byte.
// [RQ10] Next comes one 8-bit instruction byte carrying read or write.
// [RQ11] Zero or more data bytes follow, bounded only by deselection.
// [RQ12] Read data driven on serial output, write data taken from input.
// [RQ13] All bytes are shifted least significant bit first by default.
// [RQ14] All four clock modes and the bit order are selectable.
// [RQ15] Out of reset: mode 0 and first bit select zero.
// [RQ16] Interrupt marks a new frame, rests low, can be forced low.
// [RQ17] Pixel data are one 8-bit grayscale byte per pixel.
// [RQ18] To wake, host releases standby then sends the start command.
// [RQ19] Mode 0: clock idles low, sample rising, change falling.
// [RQ20] Read/write flag position and level are design parameters.
`timescale 1ns/1ps
`include "fspi_consts.svh"
module fspi_port import fspi_pkg::*; #(
    parameter int WAKE_CYCLES = `FSPI_WAKE_CYCLES,
    parameter int RW_BIT = `FSPI_RW_BIT_DEFAULT,
    parameter bit RW_READ = `FSPI_RW_READ_DEFAULT,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial pins.
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Standby and interrupt pins.
    input wire logic standby_reset_n,
    output logic irq,
    // Configuration.
    input wire logic cfg_load,
    input wire logic [1:0] cfg_mode,
    input wire logic first_bit_select,
    input wire logic cfg_irq_off,
    // Frame events from the acquisition core.
    input wire logic frame_done,
    input wire logic irq_clear,
    // Received bytes.
    output logic rx_valid,
    input wire logic rx_ready,
    output fspi_rx_t rx_word,
    // Pixel bytes to send.
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Status.
    output logic dev_ready,
    output logic sleep,
    output logic overrun
);

    localparam int STB_CYCLES = `FSPI_STANDBY_CYCLES;
    localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

    // Refuse values the logic cannot serve.
    initial begin
        if (RW_BIT < 0 || RW_BIT > 7 || WAKE_CYCLES < 1) begin
            $error("fspi_port: RW_BIT must be 0..7 and WAKE_CYCLES positive");
        end
    end

    // Pick bit p of a byte in the configured order.
    function automatic logic pick(input logic [7:0] b, input logic [2:0] p, input logic msb);
        return msb ? b[3'h7 - p] : b[p];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic ss_s1, ss_s2, sclk_s1, sclk_s2, sclk_d, mosi_s1, mosi_s2, stb_s1, stb_s2;

    // Two flip-flops on every pin before any logic looks at it.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {ss_s1, ss_s2, stb_s1, stb_s2} <= 4'hf;
            {sclk_s1, sclk_s2, sclk_d, mosi_s1, mosi_s2} <= 5'h00;
        end else begin
            ss_s1 <= ss_n;
            ss_s2 <= ss_s1;
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            mosi_s1 <= mosi;
            mosi_s2 <= mosi_s1;
            stb_s1 <= standby_reset_n;
            stb_s2 <= stb_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power and standby control.

    fspi_power_t pw_reg;
    logic [WAKE_W-1:0] wake_cnt_reg;
    logic [7:0] stb_cnt_reg;
    logic active;

    assign active = (pw_reg == FSPI_PW_RUN);

    // Wake after reset or standby release; sleep on a long enough low.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pw_reg <= FSPI_PW_WAKE;
            wake_cnt_reg <= WAKE_W'(WAKE_CYCLES - 1); // RQ1
            stb_cnt_reg <= 8'h00;
        end else begin
            stb_cnt_reg <= stb_s2 ? 8'h00 : (stb_cnt_reg == 8'(STB_CYCLES) ? stb_cnt_reg : stb_cnt_reg + 8'h01);
            if (!stb_s2 && stb_cnt_reg == 8'(STB_CYCLES - 1)) begin
                pw_reg <= FSPI_PW_SLEEP; // RQ2
            end else begin
                case (pw_reg)
                    FSPI_PW_SLEEP: begin
                        if (stb_s2) begin
                            pw_reg <= FSPI_PW_WAKE; // RQ3
                            wake_cnt_reg <= WAKE_W'(WAKE_CYCLES - 1);
                        end
                    end
                    FSPI_PW_WAKE: begin
                        if (wake_cnt_reg == '0) begin
                            pw_reg <= FSPI_PW_RUN; // RQ1 RQ3
                        end else begin
                            wake_cnt_reg <= wake_cnt_reg - 1'b1;
                        end
                    end
                    FSPI_PW_RUN: pw_reg <= FSPI_PW_RUN;
                    default: pw_reg <= FSPI_PW_WAKE;
                endcase
            end
        end
    end

    // Status outputs.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dev_ready <= 1'b0;
            sleep <= 1'b0;
        end else begin
            dev_ready <= active;
            sleep <= (pw_reg == FSPI_PW_SLEEP); // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and interrupt.

    logic [1:0] mode_reg;
    logic order_reg, irq_off_reg, irq_pend_reg;

    // Configuration is lost in sleep and must be loaded again.
    always_ff @(posedge core_clk) begin
        if (rst || pw_reg == FSPI_PW_SLEEP) begin
            mode_reg <= `FSPI_MODE_RESET; // RQ15
            order_reg <= `FSPI_ORDER_RESET; // RQ15
            irq_off_reg <= 1'b0;
        end else if (cfg_load && active) begin
            mode_reg <= cfg_mode; // RQ14
            order_reg <= first_bit_select; // RQ14
            irq_off_reg <= cfg_irq_off;
        end
    end

    // New-frame flag; a frame in the clearing cycle still sets it.
    always_ff @(posedge core_clk) begin
        if (rst || pw_reg == FSPI_PW_SLEEP) begin
            irq_pend_reg <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_pend_reg <= (frame_done && active) || (irq_pend_reg && !irq_clear);
            irq <= irq_pend_reg && !irq_off_reg; // RQ16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial clock edges and selection.

    logic sel, sel_d, rise, fall, samp, drv, sel_start;

    assign sel = active && !ss_s2; // RQ7
    assign rise = sclk_s2 && !sclk_d;
    assign fall = !sclk_s2 && sclk_d;
    // Polarity picks the leading edge, phase picks sample or change on it.
    assign samp = sel && (mode_reg[0] ? (mode_reg[1] ? rise : fall) : (mode_reg[1] ? fall : rise)); // RQ14 RQ19
    assign drv = sel && (mode_reg[0] ? (mode_reg[1] ? fall : rise) : (mode_reg[1] ? rise : fall)); // RQ19
    assign sel_start = sel && !sel_d; // RQ8

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_d <= 1'b0;
        end else begin
            sel_d <= sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive path.

    fspi_state_t st_reg;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic [2:0] rx_cnt_reg;
    logic read_op_reg, push, buf_ready;
    fspi_rx_t push_word;

    // Shift in the configured order, least significant first by default.
    assign rx_sh_next = order_reg ? {rx_sh_reg[6:0], mosi_s2} : {mosi_s2, rx_sh_reg[7:1]}; // RQ13
    assign push = samp && rx_cnt_reg == 3'h7 && (st_reg != FSPI_ST_DATA || !read_op_reg); // RQ12
    assign push_word.kind = (st_reg == FSPI_ST_ADDR) ? FSPI_KIND_ADDR :
                            (st_reg == FSPI_ST_INSTR) ? FSPI_KIND_INSTR : FSPI_KIND_DATA;
    assign push_word.data = rx_sh_next;

    // Byte counting: address, then instruction, then any number of data bytes.
    always_ff @(posedge core_clk) begin
        if (rst || !sel) begin
            st_reg <= FSPI_ST_IDLE; // RQ7 RQ8
            rx_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            read_op_reg <= 1'b0;
        end else if (sel_start) begin
            st_reg <= FSPI_ST_ADDR; // RQ8
            rx_cnt_reg <= 3'h0;
        end else if (samp) begin
            rx_sh_reg <= rx_sh_next;
            rx_cnt_reg <= rx_cnt_reg + 3'h1;
            if (rx_cnt_reg == 3'h7) begin
                case (st_reg)
                    FSPI_ST_ADDR: st_reg <= FSPI_ST_INSTR; // RQ9
                    FSPI_ST_INSTR: begin
                        st_reg <= FSPI_ST_DATA; // RQ10 RQ11
                        read_op_reg <= (rx_sh_next[RW_BIT] == RW_READ); // RQ20
                    end
                    FSPI_ST_DATA: st_reg <= FSPI_ST_DATA; // RQ11
                    default: st_reg <= FSPI_ST_IDLE;
                endcase
            end
        end
    end

    // A byte that finds the buffer full is dropped and flagged.
    always_ff @(posedge core_clk) begin
        if (rst || sel_start) begin
            overrun <= 1'b0;
        end else if (push && !buf_ready) begin
            overrun <= 1'b1;
        end
    end

    fspi_buf #(.WIDTH($bits(fspi_rx_t)), .DEPTH(BUF_DEPTH)) rx_buf (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(push),
        .in_ready(buf_ready),
        .in_data(push_word),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit path.

    logic [7:0] tx_hold_reg, out_byte_reg, cur_byte;
    logic [2:0] out_pos_reg;
    logic [1:0] drv_byte_reg;
    logic drive_now, data_rd;

    // Phase 0 shows its first bit at selection, otherwise on the change edge.
    assign drive_now = (sel_start && !mode_reg[0]) || (drv && !sel_start);
    assign data_rd = read_op_reg && drv_byte_reg == 2'h2;
    assign cur_byte = data_rd ? tx_hold_reg : 8'h00;

    // Drive one bit per change edge; the next pixel byte loads at byte start.
    always_ff @(posedge core_clk) begin
        if (rst || !sel) begin
            miso <= 1'b0;
            miso_oe <= 1'b0;
            out_pos_reg <= 3'h0;
            drv_byte_reg <= 2'h0;
            out_byte_reg <= 8'h00;
        end else begin
            miso_oe <= 1'b1;
            if (drive_now) begin
                out_pos_reg <= out_pos_reg + 3'h1;
                if (out_pos_reg == 3'h0) begin
                    out_byte_reg <= cur_byte; // RQ17
                    miso <= pick(cur_byte, 3'h0, order_reg); // RQ12 RQ13
                end else begin
                    miso <= pick(out_byte_reg, out_pos_reg, order_reg); // RQ12
                end
                if (out_pos_reg == 3'h7 && drv_byte_reg != 2'h2) begin
                    drv_byte_reg <= drv_byte_reg + 2'h1;
                end
            end
        end
    end

    // Fetch a pixel byte when a read starts and after each one is used.
    always_ff @(posedge core_clk) begin
        if (rst || !sel) begin
            tx_ready <= 1'b0;
            tx_hold_reg <= 8'h00;
        end else if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            tx_hold_reg <= tx_data; // RQ17
        end else if ((push && st_reg == FSPI_ST_INSTR && rx_sh_next[RW_BIT] == RW_READ)
                     || (drive_now && out_pos_reg == 3'h0 && data_rd)) begin
            tx_ready <= 1'b1; // RQ12
            if (drive_now) begin
                tx_hold_reg <= 8'h00;
            end
        end
    end

endmodule

// ### verification/fspi_port_props.sv
/*
 * Checker for the sensor serial slave port, bound to fspi_port.
 * Assumes it sees only the ports of fspi_port, not its internal signals, and a shortened wake count.
 */
`timescale 1ns/1ps
module fspi_port_props import fspi_pkg::*; #(
    parameter int WAKE_CYCLES = 20
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial pins.
    input wire logic ss_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    // Standby and interrupt.
    input wire logic standby_reset_n,
    input wire logic irq,
    // Configuration and events.
    input wire logic cfg_load,
    input wire logic [1:0] cfg_mode,
    input wire logic first_bit_select,
    input wire logic cfg_irq_off,
    input wire logic frame_done,
    input wire logic irq_clear,
    // Streams and status.
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire fspi_rx_t rx_word,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic dev_ready,
    input wire logic sleep,
    input wire logic overrun
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [4:0] low_cnt;
    int wake_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Counts cycles of standby low, saturating so it never wraps.
    always_ff @(posedge core_clk) begin
        if (rst || standby_reset_n) low_cnt <= 5'h0;
        else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h1;
    end

    // Counts cycles spent waking, with standby released.
    always_ff @(posedge core_clk) begin
        if (rst || dev_ready || !standby_reset_n) wake_cnt <= 0;
        else wake_cnt <= wake_cnt + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    a_wake_bound: assert property (wake_cnt <= WAKE_CYCLES + 10)
        else $error("device took too long to become ready");
    a_standby_sleep: assert property (low_cnt == 5'h18 |-> sleep && !dev_ready)
        else $error("long standby low did not put the device to sleep");
    a_sleep_quiet: assert property (sleep |-> !dev_ready && !miso_oe && !irq)
        else $error("device active while asleep");
    a_desel_quiet: assert property (ss_n [*5] |-> !miso_oe && !miso)
        else $error("serial output active while deselected");
    a_sel_drives: assert property ((!ss_n && dev_ready) [*5] |-> miso_oe)
        else $error("serial output not enabled while selected");
    a_reset_state: assert property ($past(rst) |-> !dev_ready && !irq && !rx_valid && !tx_ready)
        else $error("outputs not at rest after reset");
    a_rx_hold: assert property (rx_valid && !rx_ready && !sleep |=> sleep || (rx_valid && $stable(rx_word)))
        else $error("received word lost while stalled");
    a_tx_taken: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("pixel ready stayed high after transfer");
    a_irq_cause: assert property ($rose(irq) |-> $past(frame_done, 2) || $past(cfg_load, 2))
        else $error("interrupt rose without a frame");
    a_irq_forced: assert property (cfg_load && cfg_irq_off && dev_ready |-> ##2 !irq)
        else $error("interrupt not forced low");

    // Main scenarios reached.
    cover property ($rose(dev_ready));
    cover property (rx_valid && rx_ready && rx_word.kind == FSPI_KIND_DATA);
    cover property (tx_valid && tx_ready);
    cover property ($rose(sleep));
endmodule

bind fspi_port fspi_port_props #(.WAKE_CYCLES(WAKE_CYCLES)) i_fspi_port_props (.*);

// ### verification/fspi_host.sv
/*
 * Host model acting as serial master towards the sensor port.
 * Assumes core_clk at 8 ns; the link clock is 160 ns and runs in frames, and in noise while deselected.
 */
`timescale 1ns/1ps
module fspi_host (
    // Clock.
    input wire logic core_clk,
    // Serial pins towards the port.
    output logic ss_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Waits half a link clock period.
    task automatic half();
        repeat (10) @(posedge core_clk);
    endtask

    // Parks the clock at its idle level, then selects the device.
    task automatic sel(input logic [1:0] m);
        @(posedge core_clk);
        sclk <= m[1];
        half();
        ss_n <= 1'b0;
        half();
    endtask

    // Shifts one byte each way in the given mode and bit order.
    task automatic xb(input logic [1:0] m, input logic msb, input logic [7:0] tx,
                      output logic [7:0] rx);
        int b;
        for (int i = 0; i < 8; i++) begin
            b = msb ? 7 - i : i;
            if (m[0]) sclk <= !m[1];
            mosi <= tx[b];
            half();
            rx[b] = miso;
            sclk <= m[0] ? m[1] : !m[1];
            half();
            if (!m[0]) sclk <= m[1];
        end
    endtask

    // Ends the operation; the released data line shows no stale level.
    task automatic desel();
        half();
        ss_n <= 1'b1;
        mosi <= ~mosi;
        repeat (70) @(posedge core_clk);
    endtask

    // Toggles clock and data while the device stays deselected.
    task automatic noise();
        repeat (16) begin
            half();
            sclk <= ~sclk;
            mosi <= ~mosi;
        end
    endtask
endmodule

// ### verification/tb_top.sv
/*
 * Self-checking bench for the sensor serial slave port.
 * Assumes the host model in fspi_host.sv and a shortened wake count.
 */
`timescale 1ns/1ps
module tb_top import fspi_pkg::*;;
    localparam int WAKE = 20;
    logic core_clk, rst, ss_n, sclk, mosi, miso, miso_oe, standby_reset_n, irq;
    logic cfg_load, first_bit_select, cfg_irq_off, frame_done, irq_clear, stall, pi_clr;
    logic rx_valid, rx_ready, tx_valid, tx_ready, dev_ready, sleep, overrun;
    logic [1:0] cfg_mode;
    logic [7:0] tx_data;
    logic [7:0] pix [0:15];
    fspi_rx_t rx_word;
    fspi_rx_t rxq[$];
    fspi_rx_t expq[$];
    int n_errors, cmp_count, pi, npix, seed;

    assign tx_valid = pi < npix;
    assign tx_data = pix[pi[3:0]];

    fspi_port #(.WAKE_CYCLES(WAKE)) i_fspi_port (.*);
    fspi_host i_fspi_host (.core_clk(core_clk), .ss_n(ss_n), .sclk(sclk), .mosi(mosi),
                           .miso(miso));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Collects received words, stalls at random, advances the pixel feed.
    always @(posedge core_clk) begin
        if (rx_valid && rx_ready) rxq.push_back(rx_word);
        rx_ready <= !stall && (($random(seed) & 3) != 0);
        if (pi_clr) pi <= 0;
        else if (tx_valid && tx_ready) pi <= pi + 1;
    end

    task automatic chk_w(logic [9:0] got, logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_f(logic got, logic exp);
        chk_w({9'h0, got}, {9'h0, exp});
    endtask

    function automatic fspi_rx_t mk(fspi_kind_t k, logic [7:0] d);
        return {k, d};
    endfunction

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cfg(input logic [1:0] m, input logic o, input logic off);
        @(posedge core_clk);
        cfg_mode <= m;
        first_bit_select <= o;
        cfg_irq_off <= off;
        cfg_load <= 1'b1;
        @(posedge core_clk);
        cfg_load <= 1'b0;
    endtask

    task automatic pulse(input logic clr);
        @(posedge core_clk);
        if (clr) irq_clear <= 1'b1;
        else frame_done <= 1'b1;
        @(posedge core_clk);
        irq_clear <= 1'b0;
        frame_done <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic wait_ready();
        for (int i = 0; i < WAKE + 40 && dev_ready !== 1'b1; i++) @(posedge core_clk);
    endtask

    // One operation: address, instruction, then n data bytes.
    task automatic op(input logic [1:0] m, input logic o, input int n, input logic rd);
        logic [7:0] a, ins, d, r;
        a = 8'($random(seed));
        ins = 8'($random(seed));
        ins[7] = rd;
        @(posedge core_clk);
        pi_clr <= 1'b1;
        npix <= rd ? n : 0;
        for (int i = 0; i < n; i++) pix[i] <= 8'($random(seed));
        @(posedge core_clk);
        pi_clr <= 1'b0;
        expq = {mk(FSPI_KIND_ADDR, a), mk(FSPI_KIND_INSTR, ins)};
        i_fspi_host.sel(m);
        i_fspi_host.xb(m, o, a, r);
        i_fspi_host.xb(m, o, ins, r);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            i_fspi_host.xb(m, o, d, r);
            if (rd) chk_w({2'h0, r}, {2'h0, pix[i]});
            else expq.push_back(mk(FSPI_KIND_DATA, d));
        end
        i_fspi_host.desel();
    endtask

    task automatic chk_rx();
        chk_w(10'(rxq.size()), 10'(expq.size()));
        while (rxq.size() && expq.size()) chk_w(rxq.pop_front(), expq.pop_front());
        rxq = {};
        expq = {};
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        seed = 32'hd37dc412;
        rst = 1'b1;
        standby_reset_n = 1'b1;
        {cfg_load, cfg_mode, first_bit_select, cfg_irq_off} = 5'h0;
        {frame_done, irq_clear, stall, pi_clr} = 4'h1;
        {n_errors, cmp_count, npix} = '0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        wait_ready();
        chk_f(dev_ready, 1'b1);
        op(2'h0, 1'b0, 0, 1'b0);
        chk_rx();
        stall <= 1'b1;
        op(2'h0, 1'b0, 4, 1'b0);
        chk_f(overrun, 1'b1);
        stall <= 1'b0;
        repeat (40) @(posedge core_clk);
        chk_w(rxq[0], expq[0]);
        chk_w(rxq[1], expq[1]);
        rxq = {};
        op(2'h0, 1'b0, 1, 1'b0);
        chk_f(overrun, 1'b0);
        chk_rx();
        for (int k = 0; k < 8; k++) begin
            cfg(k[2:1], k[0], 1'b0);
            op(k[2:1], k[0], 1 + k % 3, 1'b0);
            chk_rx();
            op(k[2:1], k[0], 2, 1'b1);
            chk_rx();
        end
        i_fspi_host.noise();
        repeat (10) @(posedge core_clk);
        chk_w(10'(rxq.size()), 10'h0);
        pulse(1'b0);
        chk_f(irq, 1'b1);
        pulse(1'b1);
        chk_f(irq, 1'b0);
        pulse(1'b0);
        cfg(2'h0, 1'b0, 1'b1);
        repeat (3) @(posedge core_clk);
        chk_f(irq, 1'b0);
        cfg(2'h3, 1'b1, 1'b0);
        repeat (3) @(posedge core_clk);
        chk_f(irq, 1'b1);
        standby_reset_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        standby_reset_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk_f(sleep, 1'b0);
        chk_f(dev_ready, 1'b1);
        standby_reset_n <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk_f(sleep, 1'b1);
        chk_f(irq, 1'b0);
        standby_reset_n <= 1'b1;
        wait_ready();
        chk_f(dev_ready, 1'b1);
        op(2'h0, 1'b0, 2, 1'b0);
        chk_rx();
        cfg(2'h1, 1'b1, 1'b0);
        op(2'h1, 1'b1, 1, 1'b1);
        chk_rx();
        final_report();
    end

    // Cuts a hang short.
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        final_report();
    end
endmodule
